// [cdto_pkg.sv]
// Constants and types for the first output port timing override bank
package cdto_pkg;

   // Bank geometry
   localparam int unsigned NUM_PARAMS = 6;
   localparam int unsigned VAL_W      = 7;
   localparam int unsigned REG_W      = 8;
   localparam int unsigned FORCE_BIT  = 7;

   // Register indices, then the slot count; byte address is four times the index
   localparam logic [7:0] IDX_CLK_PREPARE  = 8'h40;
   localparam logic [7:0] IDX_CLK_ZERO     = 8'h41;
   localparam logic [7:0] IDX_CLK_TRAIL    = 8'h42;
   localparam logic [7:0] IDX_CLK_POST     = 8'h43;
   localparam logic [7:0] IDX_DATA_PREPARE = 8'h44;
   localparam logic [7:0] IDX_DATA_ZERO    = 8'h45;
   localparam logic [7:0] IDX_COUNT        = 8'h06;

   // Reset values
   localparam logic [7:0]  REG_RESET   = 8'h00;
   localparam logic [6:0]  VAL_RESET   = 7'h00;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   // AHB-Lite encodings
   localparam logic [2:0]  HSIZE_WORD  = 3'h2;
   localparam logic        HRESP_OKAY  = 1'b0;
   localparam logic [21:0] ADDR_HI_ZERO = 22'h00_0000;

   // Bus slave states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h1,
      ST_WRITE  = 4'h2,
      ST_RDWAIT = 4'h4,
      ST_RDONE  = 4'h8
   } cdto_bus_state_t;

endpackage

// [cdto_timing_cell.sv]
// One timing register: force bit, forced value, captured automatic value
`timescale 1ns/1ps
`default_nettype none

module cdto_timing_cell (
   // Clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst,
   // Register access
   input  wire logic                      wr_en,
   input  wire logic [cdto_pkg::REG_W-1:0] wr_data,
   output logic      [cdto_pkg::REG_W-1:0] rd_data,
   // Timing values
   input  wire logic [cdto_pkg::VAL_W-1:0] auto_in,
   output logic                           force_en,
   output logic      [cdto_pkg::VAL_W-1:0] eff_value
);
   import cdto_pkg::*;

   logic             force_q;
   logic [VAL_W-1:0] value_q;
   logic [VAL_W-1:0] auto_q;
   logic [VAL_W-1:0] eff_q;

   // Force bit always writable
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         force_q <= 1'b0;
      end else if (wr_en) begin
         force_q <= wr_data[FORCE_BIT];
      end
   end

   // Value field stored only by a write that leaves the force bit set
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         value_q <= VAL_RESET;
      end else if (wr_en && wr_data[FORCE_BIT]) begin
         value_q <= wr_data[VAL_W-1:0];
      end
   end

   // Capture of the computed value; reset to zero so reads start at zero
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         auto_q <= VAL_RESET;
      end else begin
         auto_q <= auto_in;
      end
   end

   // Effective value for the transmit sequencer, registered
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         eff_q <= VAL_RESET;
      end else begin
         eff_q <= force_q ? value_q : auto_q;
      end
   end

   // Read shows automatic value unless forced
   assign rd_data   = {force_q, (force_q ? value_q : auto_q)};
   assign force_en  = force_q;
   assign eff_value = eff_q;

   property p_auto_ignores_write;
      @(posedge sys_clk) disable iff (rst)
      (wr_en && !wr_data[FORCE_BIT]) |=> ($stable(value_q) && rd_data == {1'b0, auto_q});
   endproperty
   a_auto_ignores_write: assert property (p_auto_ignores_write)
      else $error("value field changed by write with force clear");

   property p_force_write_kept;
      @(posedge sys_clk) disable iff (rst)
      (wr_en && wr_data[FORCE_BIT]) ##1 !wr_en |-> rd_data == $past(wr_data);
   endproperty
   a_force_write_kept: assert property (p_force_write_kept)
      else $error("forced write not read back");

   property p_reset_zero;
      @(posedge sys_clk) $past(rst) |-> (rd_data == REG_RESET && eff_value == VAL_RESET);
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("register not zero after reset");

   property p_eff_follows;
      @(posedge sys_clk) disable iff (rst)
      !$past(rst) |-> eff_value == $past(rd_data[VAL_W-1:0]);
   endproperty
   a_eff_follows: assert property (p_eff_follows)
      else $error("effective value does not follow register");

endmodule

`default_nettype wire

// [cdto_regbank.sv]
// AHB-Lite bank of six D-PHY timing override registers for the first output port
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Clock-prepare: force bit 0 uses computed value, 1 uses bits 6:0.
// - Clock-zero: force bit 0 uses computed value, 1 uses bits 6:0.
// - Clock-trail: force bit 0 uses computed value, 1 uses bits 6:0.
// - Clock-post: force bit 0 uses computed value, 1 uses bits 6:0.
// - Data-prepare: force bit 0 uses computed value, 1 uses bits 6:0.
// - Data-zero: force bit 0 uses computed value, 1 uses bits 6:0.
// - Force bit clear: value field ignores writes, reads computed value.
// - Force bit set: value field takes writes, reads and applies stored value.
// - After reset every register reads zero, all parameters automatic.
module cdto_regbank (
   // Clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst,
   // AHB-Lite slave
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output logic                           hreadyout,
   output logic                           hresp,
   output logic      [31:0]               hrdata,
   // Computed timing values from the port's timing calculator
   input  wire logic [cdto_pkg::VAL_W-1:0] clk_prepare_auto,
   input  wire logic [cdto_pkg::VAL_W-1:0] clk_zero_auto,
   input  wire logic [cdto_pkg::VAL_W-1:0] clk_trail_auto,
   input  wire logic [cdto_pkg::VAL_W-1:0] clk_post_auto,
   input  wire logic [cdto_pkg::VAL_W-1:0] data_prepare_auto,
   input  wire logic [cdto_pkg::VAL_W-1:0] data_zero_auto,
   // Effective timing values to the transmit sequencer
   output logic      [cdto_pkg::VAL_W-1:0] clk_prepare_value,
   output logic      [cdto_pkg::VAL_W-1:0] clk_zero_value,
   output logic      [cdto_pkg::VAL_W-1:0] clk_trail_value,
   output logic      [cdto_pkg::VAL_W-1:0] clk_post_value,
   output logic      [cdto_pkg::VAL_W-1:0] data_prepare_value,
   output logic      [cdto_pkg::VAL_W-1:0] data_zero_value,
   // Force flags, for status and the sequencer
   output logic                           clk_prepare_force_en,
   output logic                           clk_zero_force_en,
   output logic                           clk_trail_force_en,
   output logic                           clk_post_force_en,
   output logic                           data_prepare_force_en,
   output logic                           data_zero_force_en
);
   import cdto_pkg::*;

   // Per-parameter wiring
   logic [VAL_W-1:0] auto_w  [NUM_PARAMS];
   logic [VAL_W-1:0] eff_w   [NUM_PARAMS];
   logic [REG_W-1:0] rdata_w [NUM_PARAMS];
   logic             force_w [NUM_PARAMS];
   logic             wr_en_w [NUM_PARAMS];

   // Bus state
   cdto_bus_state_t state_q;
   cdto_bus_state_t state_d;
   logic [2:0]      dp_slot_q;
   logic            dp_hit_q;
   logic [31:0]     hrdata_q;

   // Address phase decode
   logic       addr_take;
   logic       addr_hit;
   logic [7:0] slot_raw;

   // Gather the computed values in bank order
   assign auto_w[0] = clk_prepare_auto;
   assign auto_w[1] = clk_zero_auto;
   assign auto_w[2] = clk_trail_auto;
   assign auto_w[3] = clk_post_auto;
   assign auto_w[4] = data_prepare_auto;
   assign auto_w[5] = data_zero_auto;

   // Effective values out, each straight from a cell flip-flop
   assign clk_prepare_value  = eff_w[0];
   assign clk_zero_value     = eff_w[1];
   assign clk_trail_value    = eff_w[2];
   assign clk_post_value     = eff_w[3];
   assign data_prepare_value = eff_w[4];
   assign data_zero_value    = eff_w[5];

   // Force flags out
   assign clk_prepare_force_en  = force_w[0];
   assign clk_zero_force_en     = force_w[1];
   assign clk_trail_force_en    = force_w[2];
   assign clk_post_force_en     = force_w[3];
   assign data_prepare_force_en = force_w[4];
   assign data_zero_force_en    = force_w[5];

   // Address phase: only whole-word accesses to the six slots are mapped
   assign addr_take = hsel && htrans[1] && hready;
   assign slot_raw  = haddr[9:2] - IDX_CLK_PREPARE;
   assign addr_hit  = (haddr[31:10] == ADDR_HI_ZERO) && (haddr[1:0] == 2'b00)
                      && (slot_raw < IDX_COUNT) && (hsize == HSIZE_WORD);

   // Next bus state; a read takes one wait state so read data is registered
   always_comb begin
      state_d = ST_IDLE;
      case (state_q)
         ST_IDLE, ST_WRITE, ST_RDONE: begin
            if (addr_take) begin
               state_d = hwrite ? ST_WRITE : ST_RDWAIT;
            end else begin
               state_d = ST_IDLE;
            end
         end
         ST_RDWAIT: begin
            state_d = ST_RDONE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Bus state register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Data phase target, latched at the end of the address phase
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dp_slot_q <= 3'h0;
         dp_hit_q  <= 1'b0;
      end else if (addr_take) begin
         dp_slot_q <= slot_raw[2:0];
         dp_hit_q  <= addr_hit;
      end
   end

   // Read data; unmapped addresses read zero
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hrdata_q <= RDATA_RESET;
      end else if (state_q == ST_RDWAIT) begin
         hrdata_q <= dp_hit_q ? {24'h00_0000, rdata_w[dp_slot_q]} : RDATA_RESET;
      end
   end

   // Handshake: low only in the read wait state
   assign hreadyout = (state_q != ST_RDWAIT);
   assign hresp     = HRESP_OKAY;
   assign hrdata    = hrdata_q;

   // Reads cost exactly one wait state; a master polling ready relies on it ending
   property p_read_one_wait;
      @(posedge sys_clk) disable iff (rst)
      (addr_take && !hwrite) |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_one_wait: assert property (p_read_one_wait)
      else $error("read wait state not exactly one cycle");

   // Writes complete with no wait state
   property p_write_no_wait;
      @(posedge sys_clk) disable iff (rst)
      (addr_take && hwrite) |=> hreadyout;
   endproperty
   a_write_no_wait: assert property (p_write_no_wait)
      else $error("write data phase stalled");

   // A mapped read returns the addressed register as it stood in the wait state
   property p_read_data;
      @(posedge sys_clk) disable iff (rst)
      (state_q == ST_RDWAIT && dp_hit_q) |=> hrdata == {24'h00_0000, $past(rdata_w[dp_slot_q])};
   endproperty
   a_read_data: assert property (p_read_data)
      else $error("read data differs from addressed register");

   // Out of reset the bus is ready and read data is zero
   property p_reset_bus;
      @(posedge sys_clk) rst |=> hreadyout && hrdata == RDATA_RESET;
   endproperty
   a_reset_bus: assert property (p_reset_bus)
      else $error("bus not idle after reset");

   // One register cell per timing parameter
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PARAMS; gi++) begin : g_cell
         // Write lands in the data phase; upper hwdata bits are dropped
         assign wr_en_w[gi] = (state_q == ST_WRITE) && dp_hit_q && (dp_slot_q == 3'(gi));

         cdto_timing_cell u_cell (
            .sys_clk   (sys_clk),
            .rst       (rst),
            .wr_en     (wr_en_w[gi]),
            .wr_data   (hwdata[REG_W-1:0]),
            .rd_data   (rdata_w[gi]),
            .auto_in   (auto_w[gi]),
            .force_en  (force_w[gi]),
            .eff_value (eff_w[gi])
         );

         // Auto mode reads show the computed input one edge back
         property p_read_auto;
            @(posedge sys_clk) disable iff (rst)
            (!$past(rst) && !force_w[gi]) |-> rdata_w[gi] == {1'b0, $past(auto_w[gi])};
         endproperty
         a_read_auto: assert property (p_read_auto)
            else $error("auto mode read does not show computed value");

         // A write with force clear leaves the field showing the computed value
         property p_write_dropped;
            @(posedge sys_clk) disable iff (rst)
            (wr_en_w[gi] && !hwdata[FORCE_BIT]) |=> rdata_w[gi] == {1'b0, $past(auto_w[gi])};
         endproperty
         a_write_dropped: assert property (p_write_dropped)
            else $error("value write taken with force clear");

         // A write with force set is read back whole on the next cycle
         property p_write_taken;
            @(posedge sys_clk) disable iff (rst)
            (wr_en_w[gi] && hwdata[FORCE_BIT]) |=> rdata_w[gi] == $past(hwdata[REG_W-1:0]);
         endproperty
         a_write_taken: assert property (p_write_taken)
            else $error("forced write not read back");

         // Unforced, the sequencer sees the computed input two edges late
         property p_eff_auto;
            @(posedge sys_clk) disable iff (rst)
            (!$past(rst) && !$past(rst, 2) && !$past(force_w[gi]))
               |-> eff_w[gi] == $past(auto_w[gi], 2);
         endproperty
         a_eff_auto: assert property (p_eff_auto)
            else $error("sequencer value does not follow computed value");

         // Forced, the sequencer sees the written value one edge after it reads back
         property p_eff_forced;
            @(posedge sys_clk) disable iff (rst)
            (wr_en_w[gi] && hwdata[FORCE_BIT]) ##1 !wr_en_w[gi]
               |=> force_w[gi] && eff_w[gi] == $past(hwdata[VAL_W-1:0], 2);
         endproperty
         a_eff_forced: assert property (p_eff_forced)
            else $error("sequencer value does not apply forced write");

         // Reset clears force, field and sequencer value alike
         property p_reset_clear;
            @(posedge sys_clk) rst |=> !force_w[gi] && rdata_w[gi] == REG_RESET && eff_w[gi] == VAL_RESET;
         endproperty
         a_reset_clear: assert property (p_reset_clear)
            else $error("register not cleared by reset");
      end
   endgenerate

   // Effective value is the force-selected source, two edges behind the input
   property p_clk_prepare_sel;
      @(posedge sys_clk) disable iff (rst)
      (!$past(rst) && !$past(rst, 2) && !$past(clk_prepare_force_en))
         |-> clk_prepare_value == $past(clk_prepare_auto, 2);
   endproperty
   a_clk_prepare_sel: assert property (p_clk_prepare_sel)
      else $error("clock-prepare does not follow computed value");

   property p_clk_zero_sel;
      @(posedge sys_clk) disable iff (rst)
      (!$past(rst) && $past(clk_zero_force_en))
         |-> clk_zero_value == $past(rdata_w[1][VAL_W-1:0]);
   endproperty
   a_clk_zero_sel: assert property (p_clk_zero_sel)
      else $error("clock-zero does not apply forced value");

   property p_clk_trail_sel;
      @(posedge sys_clk) disable iff (rst)
      (!$past(rst) && !$past(rst, 2) && !$past(clk_trail_force_en))
         |-> clk_trail_value == $past(clk_trail_auto, 2);
   endproperty
   a_clk_trail_sel: assert property (p_clk_trail_sel)
      else $error("clock-trail does not follow computed value");

   property p_clk_post_sel;
      @(posedge sys_clk) disable iff (rst)
      (wr_en_w[3] && hwdata[FORCE_BIT]) ##1 !wr_en_w[3] ##1 !wr_en_w[3]
         |-> clk_post_force_en && clk_post_value == $past(hwdata[VAL_W-1:0], 2);
   endproperty
   a_clk_post_sel: assert property (p_clk_post_sel)
      else $error("clock-post forced write not applied");

   property p_data_prepare_sel;
      @(posedge sys_clk) disable iff (rst)
      (!$past(rst) && !$past(rst, 2) && !$past(data_prepare_force_en))
         |-> data_prepare_value == $past(data_prepare_auto, 2);
   endproperty
   a_data_prepare_sel: assert property (p_data_prepare_sel)
      else $error("data-prepare does not follow computed value");

   property p_data_zero_sel;
      @(posedge sys_clk) disable iff (rst)
      (wr_en_w[5] && hwdata[FORCE_BIT]) ##1 !wr_en_w[5] ##1 !wr_en_w[5]
         |-> data_zero_force_en && data_zero_value == $past(hwdata[VAL_W-1:0], 2);
   endproperty
   a_data_zero_sel: assert property (p_data_zero_sel)
      else $error("data-zero forced write not applied");

endmodule

`default_nettype wire

// [cdto_regbank_tb.sv]
// Self-checking bench for the first output port timing override bank
`timescale 1ns/1ps
`default_nettype none

module cdto_regbank_tb;
   import cdto_pkg::*;

   // Bus master side
   logic        sys_clk   = 1'b0;
   logic        rst       = 1'b1;
   logic        hsel      = 1'b0;
   logic        hwrite    = 1'b0;
   logic [1:0]  htrans    = 2'h0;
   logic [2:0]  hsize     = HSIZE_WORD;
   logic [31:0] haddr     = 32'h0000_0000;
   logic [31:0] hwdata    = 32'h0000_0000;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   // Timing values, one slot per parameter
   logic [6:0]  auto_v [6] = '{default: 7'h00};
   logic [6:0]  val_w  [6];
   logic        frc_w  [6];
   int          fail_count = 0;
   int          checks     = 0;
   int          cyc        = 0;

   // 40 MHz clock
   always #12.5 sys_clk = ~sys_clk;

   // Single slave, so its ready is the bus ready
   cdto_regbank dut (
      .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata),
      .clk_prepare_auto(auto_v[0]), .clk_zero_auto(auto_v[1]), .clk_trail_auto(auto_v[2]),
      .clk_post_auto(auto_v[3]), .data_prepare_auto(auto_v[4]), .data_zero_auto(auto_v[5]),
      .clk_prepare_value(val_w[0]), .clk_zero_value(val_w[1]), .clk_trail_value(val_w[2]),
      .clk_post_value(val_w[3]), .data_prepare_value(val_w[4]), .data_zero_value(val_w[5]),
      .clk_prepare_force_en(frc_w[0]), .clk_zero_force_en(frc_w[1]), .clk_trail_force_en(frc_w[2]),
      .clk_post_force_en(frc_w[3]), .data_prepare_force_en(frc_w[4]), .data_zero_force_en(frc_w[5])
   );

   // Byte address is four times the register index
   function automatic logic [31:0] ra(input int i);
      return {22'h00_0000, IDX_CLK_PREPARE + 8'(i), 2'h0};
   endfunction

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         end_of_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Force flag and effective value of one parameter
   task automatic chk_out(input int i, input logic [7:0] exp);
      chk({24'h00_0000, frc_w[i], val_w[i]}, {24'h00_0000, exp}, "sequencer value");
   endtask

   // One AHB-Lite single transfer; waits on ready in both phases
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      input logic [2:0] sz, output logic [31:0] rd);
      int n;
      @(posedge sys_clk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize  <= sz;
      n = 0;
      do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 16);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      n = 0;
      do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 16);
      rd = hrdata;
      chk({31'h0000_0000, hresp}, {31'h0000_0000, HRESP_OKAY}, "response");
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz = HSIZE_WORD);
      logic [31:0] r;
      bus(1'b1, a, d, sz, r);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0000_0000, HSIZE_WORD, r);
      chk(r, exp, "read data");
   endtask

   // Computed values settle on the outputs two edges later
   task automatic set_auto(input logic [6:0] b);
      foreach (auto_v[i]) auto_v[i] <= b + 7'(i);
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic t_reset();
      @(posedge sys_clk);
      foreach (auto_v[i]) auto_v[i] <= 7'h00;
      rst <= 1'b1;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd_chk(ra(i), 32'h0000_0000);
         chk_out(i, 8'h00);
      end
      $display("test reset done");
   endtask

   // Auto mode: reads track computed value, value writes are dropped
   task automatic t_auto(input logic [6:0] b);
      set_auto(b);
      for (int i = 0; i < 6; i++) begin
         rd_chk(ra(i), {25'h0, b + 7'(i)});
         chk_out(i, {1'b0, b + 7'(i)});
         wr(ra(i), 32'hFFFF_FF7F);
         rd_chk(ra(i), {25'h0, b + 7'(i)});
      end
      $display("test auto done");
   endtask

   // Override: stored value read back and applied, computed input ignored
   task automatic t_force(input logic [6:0] f);
      for (int i = 0; i < 6; i++) begin
         wr(ra(i), {24'h0, 1'b1, f + 7'(i)});
         rd_chk(ra(i), {24'h0, 1'b1, f + 7'(i)});
      end
      set_auto(7'h55);
      for (int i = 0; i < 6; i++) begin
         chk_out(i, {1'b1, f + 7'(i)});
      end
      $display("test force done");
   endtask

   // Leaving override hands control back to the computed value
   task automatic t_release(input logic [6:0] b);
      for (int i = 0; i < 6; i++) wr(ra(i), 32'h0000_0000);
      set_auto(b);
      for (int i = 0; i < 6; i++) begin
         rd_chk(ra(i), {25'h0, b + 7'(i)});
         chk_out(i, {1'b0, b + 7'(i)});
      end
      $display("test release done");
   endtask

   // Unmapped, misaligned and byte-sized accesses must not touch the bank
   task automatic t_refuse(input logic [6:0] b);
      wr(32'h0000_0118, 32'h0000_00FF);
      wr(32'h0000_00FC, 32'h0000_00FF);
      wr(32'h0000_0101, 32'h0000_00FF);
      wr(ra(0), 32'h0000_00FF, 3'h0);
      rd_chk(32'h0000_0118, 32'h0000_0000);
      rd_chk(32'h0000_00FC, 32'h0000_0000);
      rd_chk(32'h0000_0101, 32'h0000_0000);
      rd_chk(32'h0001_0100, 32'h0000_0000);
      rd_chk(ra(0), {25'h0, b});
      chk_out(0, {1'b0, b});
      $display("test refuse done");
   endtask

   // Main sequence, with a second reset while overrides are active
   initial begin
      t_reset();
      t_auto(7'h11);
      t_force(7'h79);
      t_release(7'h2A);
      t_refuse(7'h2A);
      t_force(7'h00);
      t_reset();
      t_auto(7'h3C);
      end_of_test();
   end
endmodule

`default_nettype wire
